/* File: hot_alert_profile_config.sv */
// Purpose: thresholds, deglitch and profile gating of the processor-hot alert
// Assumes: measurements arrive as synchronous binary values in mA and mV
// Notes: alert pin is open drain; register port is the decoded I2C side
`default_nettype none

module hot_alert_profile_config
   import hot_alert_pkg::*;
#(
   parameter int unsigned CRIT0_CYCLES = CRIT0_CYC,
   parameter int unsigned CRIT1_CYCLES = CRIT1_CYC,
   parameter int unsigned CRIT2_CYCLES = CRIT2_CYC,
   parameter int unsigned CRIT3_CYCLES = CRIT3_CYC,
   parameter int unsigned NOM0_CYCLES  = NOM0_CYC,
   parameter int unsigned NOM1_CYCLES  = NOM1_CYC,
   parameter int unsigned DIS0_CYCLES  = DIS0_CYC,
   parameter int unsigned DIS1_CYCLES  = DIS1_CYC,
   parameter int unsigned DIS2_CYCLES  = DIS2_CYC,
   parameter int unsigned DIS3_CYCLES  = DIS3_CYC
)
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // register port
   input  wire logic [7:0]  regAddr,
   input  wire logic        regWrite,
   input  wire logic [7:0]  regWrData,
   output logic      [7:0]  regRdData,
   // measurements and limits
   input  wire logic [15:0] inputCurrentMa,
   input  wire logic [15:0] inputCurrentLimitMa,
   input  wire logic [15:0] inputVoltageMv,
   input  wire logic [15:0] inputVoltageLimitMv,
   input  wire logic [15:0] systemVoltageMv,
   input  wire logic [15:0] dischargeCurrentMa,
   input  wire logic        comparatorEvent,
   // mode inputs
   input  wire logic        singleCell,
   input  wire logic        lowPowerMode,
   input  wire logic        lowPowerAlertEnable,
   input  wire logic        voltageAssistMode,
   input  wire logic [1:0]  extraProfileBits,
   // results
   output logic      [7:0]  statusEvents,
   output logic             alertFunctionEnabled,
   output logic             busDischargeTrigger,
   output logic             alertPinOut,
   output logic             alertPinOe
);

   ////////////////////////////////////////////////////////////////////////////
   // register file
   logic [5:0] sysThr_q;
   logic [5:0] sysThr_d;
   logic       nomDeg_q;
   logic       nomDeg_d;
   logic       lowerEn_q;
   logic       lowerEn_d;
   logic [7:0] l2Cfg_q;
   logic [7:0] l2Cfg_d;
   logic [7:0] profile_q;
   logic [7:0] profile_d;
   logic [7:0] disCfg_q;
   logic [7:0] disCfg_d;
   logic       strapDone_q;
   logic       strapDone_d;
   logic [7:0] rdData_q;
   logic [7:0] rdData_d;

   always_comb
   begin
      sysThr_d    = sysThr_q;
      nomDeg_d    = nomDeg_q;
      lowerEn_d   = lowerEn_q;
      l2Cfg_d     = l2Cfg_q;
      profile_d   = profile_q;
      disCfg_d    = disCfg_q;
      strapDone_d = 1'b1;
      if (!strapDone_q)
         sysThr_d = singleCell ? RST_SYS_THR_SINGLE : RST_SYS_THR_MULTI;
      if (regWrite)
      begin
         case (regAddr)
            ADDR_SYS_NOM_CFG:
            begin
               sysThr_d  = regWrData[7:SYS_THR_LSB];
               nomDeg_d  = regWrData[NOM_DEG_BIT];
               lowerEn_d = regWrData[LOWER_EN_BIT];
            end
            ADDR_L2_VIN_CFG:    l2Cfg_d   = regWrData;
            ADDR_PROFILE_EN:    profile_d = regWrData;
            ADDR_DISCHARGE_CFG: disCfg_d  = regWrData;
            default:            ;
         endcase
      end
      case (regAddr)
         ADDR_SYS_NOM_CFG:   rdData_d = {sysThr_q, nomDeg_q, lowerEn_q};
         ADDR_L2_VIN_CFG:    rdData_d = l2Cfg_q;
         ADDR_PROFILE_EN:    rdData_d = profile_q;
         ADDR_DISCHARGE_CFG: rdData_d = disCfg_q;
         default:            rdData_d = READ_UNMAPPED;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sysThr_q    <= RST_SYS_NOM_MULTI[7:SYS_THR_LSB];
         nomDeg_q    <= RST_SYS_NOM_MULTI[NOM_DEG_BIT];
         lowerEn_q   <= RST_SYS_NOM_MULTI[LOWER_EN_BIT];
         l2Cfg_q     <= RST_L2_VIN_CFG;
         profile_q   <= RST_PROFILE_EN;
         disCfg_q    <= RST_DISCHARGE_CFG;
         strapDone_q <= 1'b0;
         rdData_q    <= READ_UNMAPPED;
      end
      else if (ce)
      begin
         sysThr_q    <= sysThr_d;
         nomDeg_q    <= nomDeg_d;
         lowerEn_q   <= lowerEn_d;
         l2Cfg_q     <= l2Cfg_d;
         profile_q   <= profile_d;
         disCfg_q    <= disCfg_d;
         strapDone_q <= strapDone_d;
         rdData_q    <= rdData_d;
      end
   end

   assign regRdData = rdData_q;

   ////////////////////////////////////////////////////////////////////////////
   // field views
   logic [4:0] l2Code;
   logic [1:0] critDegSel;
   logic       lowSelect;
   logic [5:0] disThrCode;
   logic [1:0] disDegSel;

   assign l2Code     = l2Cfg_q[7:L2_CODE_LSB];
   assign critDegSel = l2Cfg_q[L2_CODE_LSB-1:CRIT_DEG_LSB];
   assign lowSelect  = l2Cfg_q[LOW_SEL_BIT];
   assign disThrCode = disCfg_q[7:DIS_THR_LSB];
   assign disDegSel  = disCfg_q[DIS_THR_LSB-1:DIS_DEG_LSB];

   ////////////////////////////////////////////////////////////////////////////
   // level-2 and critical current compare
   logic [8:0]  l2Pct;
   logic        l2Valid;
   logic [31:0] limitWide;
   logic [31:0] currentWide;
   logic [31:0] critLhs;
   logic [31:0] critRhs;
   logic        critAbove;

   always_comb
   begin
      l2Pct   = L2_FINE_BASE;
      l2Valid = 1'b0;
      if ((l2Code != L2_CODE_NONE) && (l2Code <= L2_CODE_FINE_MAX))
      begin
         l2Pct   = 9'(L2_FINE_BASE + L2_FINE_STEP * 9'(l2Code));
         l2Valid = 1'b1;
      end
      else if ((l2Code >= L2_CODE_COARSE0) && (l2Code != L2_CODE_IGNORED))
      begin
         l2Pct   = 9'(L2_COARSE_BASE
                      + L2_COARSE_STEP * 9'(l2Code - L2_CODE_COARSE0));
         l2Valid = 1'b1;
      end
   end

   assign limitWide   = {16'h0000, inputCurrentLimitMa};
   assign currentWide = {16'h0000, inputCurrentMa};
   assign critLhs   = currentWide * CRIT_LHS_SCALE;
   assign critRhs   = limitWide * {23'h000000, l2Pct} * CRIT_RHS_SCALE;
   assign critAbove = l2Valid && (critLhs > critRhs);

   ////////////////////////////////////////////////////////////////////////////
   // nominal current, input voltage, system voltage, discharge
   logic        nomAbove;
   logic [31:0] vinPct;
   logic        vinBelow;
   logic [5:0]  sysCode;
   logic [31:0] sysThrMv;
   logic        sysBelow;
   logic        disAbove;

   assign nomAbove = (currentWide * NOM_LHS_SCALE)
                     > (limitWide * NOM_RHS_SCALE);

   assign vinPct   = !lowerEn_q ? PCT_FULL
                     : (lowSelect ? VIN_PCT_HIGH : VIN_PCT_LOW);
   assign vinBelow = ({16'h0000, inputVoltageMv} * PCT_FULL)
                     < ({16'h0000, inputVoltageLimitMv} * vinPct);

   assign sysCode  = singleCell ? (sysThr_q & SYS_SINGLE_MASK) : sysThr_q;
   assign sysThrMv = SYS_OFFSET_MV + SYS_STEP_MV * {26'h0000000, sysCode};
   assign sysBelow = {16'h0000, systemVoltageMv} < sysThrMv;

   assign disAbove = {16'h0000, dischargeCurrentMa}
                     > (DIS_STEP_MA * {26'h0000000, disThrCode});

   ////////////////////////////////////////////////////////////////////////////
   // deglitch timers
   deglitch_if dg [NUM_CH] ();
   logic [31:0] critLimit;
   logic [31:0] nomLimit;
   logic [31:0] disLimit;

   always_comb
   begin
      case (critDegSel)
         2'h0:    critLimit = 32'(CRIT0_CYCLES);
         2'h1:    critLimit = 32'(CRIT1_CYCLES);
         2'h2:    critLimit = 32'(CRIT2_CYCLES);
         default: critLimit = 32'(CRIT3_CYCLES);
      endcase
      case (disDegSel)
         2'h0:    disLimit = 32'(DIS0_CYCLES);
         2'h1:    disLimit = 32'(DIS1_CYCLES);
         2'h2:    disLimit = 32'(DIS2_CYCLES);
         default: disLimit = 32'(DIS3_CYCLES);
      endcase
      nomLimit = nomDeg_q ? 32'(NOM1_CYCLES) : 32'(NOM0_CYCLES);
   end

   assign dg[CH_CRIT].cond  = critAbove;
   assign dg[CH_CRIT].limit = critLimit;
   assign dg[CH_NOM].cond   = nomAbove;
   assign dg[CH_NOM].limit  = nomLimit;
   assign dg[CH_VIN].cond   = vinBelow;
   assign dg[CH_VIN].limit  = 32'(VIN_CYC);
   assign dg[CH_SYS].cond   = sysBelow;
   assign dg[CH_SYS].limit  = 32'(SYS_CYC);
   assign dg[CH_DIS].cond   = disAbove;
   assign dg[CH_DIS].limit  = disLimit;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++)
      begin : g_timer
         deglitch_timer u_timer (
            .mclk  (mclk),
            .rst_n (rst_n),
            .ce    (ce),
            .dg    (dg[ch])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // profile gating and alert pin
   logic       compProfile;
   logic       funcEn;
   logic [7:0] events;
   logic [7:0] gated;
   logic [7:0] status_q;
   logic [7:0] status_d;
   logic       funcEn_q;
   logic       alertOe_q;
   logic       alertOe_d;
   logic       busDis_q;
   logic       busDis_d;

   assign compProfile = lowPowerMode ? lowPowerAlertEnable
                                     : profile_q[PROF_COMP_BIT];
   assign funcEn = (|profile_q) || (|extraProfileBits);

   always_comb
   begin
      events = 8'h00;
      events[PROF_VIN_BIT]  = dg[CH_VIN].detected;
      events[PROF_COMP_BIT] = comparatorEvent;
      events[PROF_CRIT_BIT] = dg[CH_CRIT].detected;
      events[PROF_NOM_BIT]  = dg[CH_NOM].detected;
      events[PROF_DIS_BIT]  = dg[CH_DIS].detected;
      gated = events & profile_q;
      gated[PROF_COMP_BIT] = comparatorEvent && compProfile;
      status_d  = funcEn ? gated : 8'h00;
      alertOe_d = |status_d;
      busDis_d  = voltageAssistMode && dg[CH_SYS].detected;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_q  <= 8'h00;
         funcEn_q  <= 1'b0;
         alertOe_q <= 1'b0;
         busDis_q  <= 1'b0;
      end
      else if (ce)
      begin
         status_q  <= status_d;
         funcEn_q  <= funcEn;
         alertOe_q <= alertOe_d;
         busDis_q  <= busDis_d;
      end
   end

   assign statusEvents         = status_q;
   assign alertFunctionEnabled = funcEn_q;
   assign busDischargeTrigger  = busDis_q;
   assign alertPinOut          = 1'b0;
   assign alertPinOe           = alertOe_q;

endmodule : hot_alert_profile_config

`default_nettype wire

/* File: hot_alert_pkg.sv */
// Purpose: constants shared by the processor-hot alert configuration block
// Assumes: 50 MHz mclk, register writes arrive already decoded from I2C
// Notes: times are in ns, cycle counts derive from the clock period
// Function
// - level-2 code is percent of input limit
// - all-ones level-2 code is ignored
// - critical level is 110% of level-2
// - critical deglitch 15/100/400/800 us select
// - low select picks 83% or 91%
// - lower enable picks limit or reduced threshold
// - system threshold 3.2 V plus 100 mV steps
// - single cell decodes low three bits only
// - system threshold reset depends on cell count
// - nominal level 10% above, 1/60 ms deglitch
// - cleared profile bit blocks status and pin
// - discharge threshold 1024 mA per code
// - discharge deglitch 78 ms/1.25/5/20 s select
// - all profile bits zero disables alert
// - low power mode swaps comparator profile control
// - profile bits 7..3 enable sources, reset 10100
`default_nettype none

package hot_alert_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [7:0] ADDR_SYS_NOM_CFG    = 8'h36;
   localparam logic [7:0] ADDR_L2_VIN_CFG     = 8'h37;
   localparam logic [7:0] ADDR_PROFILE_EN     = 8'h38;
   localparam logic [7:0] ADDR_DISCHARGE_CFG  = 8'h39;

   // reset values
   localparam logic [7:0] RST_SYS_NOM_MULTI   = 8'h81;
   localparam logic [5:0] RST_SYS_THR_MULTI   = 6'h20;
   localparam logic [5:0] RST_SYS_THR_SINGLE  = 6'h02;
   localparam logic [7:0] RST_L2_VIN_CFG      = 8'h4A;
   localparam logic [7:0] RST_PROFILE_EN      = 8'hA0;
   localparam logic [7:0] RST_DISCHARGE_CFG   = 8'h41;
   localparam logic [7:0] READ_UNMAPPED       = 8'h00;

   // field positions
   localparam int SYS_THR_LSB      = 2;
   localparam int NOM_DEG_BIT      = 1;
   localparam int LOWER_EN_BIT     = 0;
   localparam int L2_CODE_LSB      = 3;
   localparam int CRIT_DEG_LSB     = 1;
   localparam int LOW_SEL_BIT      = 0;
   localparam int DIS_THR_LSB      = 2;
   localparam int DIS_DEG_LSB      = 0;
   localparam int PROF_VIN_BIT     = 7;
   localparam int PROF_COMP_BIT    = 6;
   localparam int PROF_CRIT_BIT    = 5;
   localparam int PROF_NOM_BIT     = 4;
   localparam int PROF_DIS_BIT     = 3;

   // level-2 code table
   localparam logic [4:0] L2_CODE_NONE     = 5'h00;
   localparam logic [4:0] L2_CODE_FINE_MAX = 5'h19;
   localparam logic [4:0] L2_CODE_COARSE0  = 5'h1A;
   localparam logic [4:0] L2_CODE_IGNORED  = 5'h1F;
   localparam logic [8:0] L2_FINE_BASE     = 9'h069;
   localparam logic [8:0] L2_FINE_STEP     = 9'h005;
   localparam logic [8:0] L2_COARSE_BASE   = 9'h0FA;
   localparam logic [8:0] L2_COARSE_STEP   = 9'h032;

   // scaling factors for comparisons without division
   localparam logic [31:0] PCT_FULL        = 32'h0000_0064;
   localparam logic [31:0] CRIT_LHS_SCALE  = 32'h0000_03E8;
   localparam logic [31:0] CRIT_RHS_SCALE  = 32'h0000_000B;
   localparam logic [31:0] NOM_LHS_SCALE   = 32'h0000_000A;
   localparam logic [31:0] NOM_RHS_SCALE   = 32'h0000_000B;
   localparam logic [31:0] VIN_PCT_LOW     = 32'h0000_0053;
   localparam logic [31:0] VIN_PCT_HIGH    = 32'h0000_005B;
   localparam logic [31:0] SYS_OFFSET_MV   = 32'h0000_0C80;
   localparam logic [31:0] SYS_STEP_MV     = 32'h0000_0064;
   localparam logic [31:0] DIS_STEP_MA     = 32'h0000_0400;
   localparam logic [5:0]  SYS_SINGLE_MASK = 6'h07;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam longint CLK_PERIOD_NS   = 20;
   localparam longint T_CRIT0_NS      = 15000;
   localparam longint T_CRIT1_NS      = 100000;
   localparam longint T_CRIT2_NS      = 400000;
   localparam longint T_CRIT3_NS      = 800000;
   localparam longint T_NOM0_NS       = 1000000;
   localparam longint T_NOM1_NS       = 60000000;
   localparam longint T_SYS_NS        = 5000;
   localparam longint T_VIN_NS        = 20;
   localparam longint T_DIS0_NS       = 78000000;
   localparam longint T_DIS1_NS       = 1250000000;
   localparam longint T_DIS2_NS       = 5000000000;
   localparam longint T_DIS3_NS       = 20000000000;

   localparam int unsigned CRIT0_CYC  = int'(T_CRIT0_NS / CLK_PERIOD_NS);
   localparam int unsigned CRIT1_CYC  = int'(T_CRIT1_NS / CLK_PERIOD_NS);
   localparam int unsigned CRIT2_CYC  = int'(T_CRIT2_NS / CLK_PERIOD_NS);
   localparam int unsigned CRIT3_CYC  = int'(T_CRIT3_NS / CLK_PERIOD_NS);
   localparam int unsigned NOM0_CYC   = int'(T_NOM0_NS / CLK_PERIOD_NS);
   localparam int unsigned NOM1_CYC   = int'(T_NOM1_NS / CLK_PERIOD_NS);
   localparam int unsigned SYS_CYC    = int'(T_SYS_NS / CLK_PERIOD_NS);
   localparam int unsigned VIN_CYC    = int'(T_VIN_NS / CLK_PERIOD_NS);
   localparam int unsigned DIS0_CYC   = int'(T_DIS0_NS / CLK_PERIOD_NS);
   localparam int unsigned DIS1_CYC   = int'(T_DIS1_NS / CLK_PERIOD_NS);
   localparam int unsigned DIS2_CYC   = int'(T_DIS2_NS / CLK_PERIOD_NS);
   localparam int unsigned DIS3_CYC   = int'(T_DIS3_NS / CLK_PERIOD_NS);

   // timer channel indices
   localparam int CH_CRIT  = 0;
   localparam int CH_NOM   = 1;
   localparam int CH_VIN   = 2;
   localparam int CH_SYS   = 3;
   localparam int CH_DIS   = 4;
   localparam int NUM_CH   = 5;

endpackage : hot_alert_pkg

`default_nettype wire

/* File: deglitch_if.sv */
// Purpose: carries one condition, its persist count and the detected flag
// Assumes: limit is held stable while the condition is timed
// Notes: a limit of zero behaves like one
`default_nettype none

interface deglitch_if;
   logic        cond;
   logic [31:0] limit;
   logic        detected;

   modport timer (input cond, input limit, output detected);
   modport user  (output cond, output limit, input detected);
endinterface : deglitch_if

`default_nettype wire

/* File: deglitch_timer.sv */
// Purpose: reports a condition only after it held for limit cycles
// Assumes: cond is synchronous to mclk
// Notes: any drop of cond clears the count and the flag
`default_nettype none

module deglitch_timer
   import hot_alert_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic ce,
   deglitch_if.timer dg
);

   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic        det_q;
   logic        det_d;
   logic [31:0] cntNext;

   assign cntNext = cnt_q + 32'h0000_0001;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      cnt_d = cnt_q;
      det_d = det_q;
      if (!dg.cond)
      begin
         cnt_d = 32'h0000_0000;
         det_d = 1'b0;
      end
      else if (!det_q)
      begin
         if (cntNext >= dg.limit)
            det_d = 1'b1;
         else
            cnt_d = cntNext;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= 32'h0000_0000;
         det_q <= 1'b0;
      end
      else if (ce)
      begin
         cnt_q <= cnt_d;
         det_q <= det_d;
      end
   end

   assign dg.detected = det_q;

endmodule : deglitch_timer

`default_nettype wire

/* File: hot_alert_chk_sva.sv */
// Purpose: port-level assertions of the alert block
// Assumes: ce held high
// Notes: bound from the bench top file
`default_nettype none

module hot_alert_chk
(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic [7:0]  regAddr,
   input wire logic [7:0]  regRdData,
   input wire logic [15:0] inputCurrentMa,
   input wire logic [15:0] inputCurrentLimitMa,
   input wire logic [15:0] inputVoltageMv,
   input wire logic [15:0] inputVoltageLimitMv,
   input wire logic [15:0] dischargeCurrentMa,
   input wire logic        comparatorEvent,
   input wire logic        voltageAssistMode,
   input wire logic [7:0]  statusEvents,
   input wire logic        busDischargeTrigger,
   input wire logic        alertPinOut,
   input wire logic        alertPinOe
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////////
   a_pin_drive_low: assert property (alertPinOut == 1'b0)
      else $error("pin data not low");
   a_low_bits_zero: assert property (statusEvents[2:0] == 3'h0)
      else $error("unused status bits set");
   a_pin_follows_ev: assert property (
      alertPinOe == (|statusEvents[7:3])) else $error("pin enable vs events");
   a_comp_rise_cause: assert property ($rose(statusEvents[6]) |->
      $past(comparatorEvent)) else $error("comp status no event");
   a_comp_drop_clear: assert property (!comparatorEvent |=>
      !statusEvents[6]) else $error("comp status stuck");
   a_crit_rise_cause: assert property ($rose(statusEvents[5]) |->
      $past(inputCurrentMa, 2) > $past(inputCurrentLimitMa, 2))
      else $error("crit status no current");
   a_vin_rise_cause: assert property ($rose(statusEvents[7]) |->
      $past(inputVoltageMv, 2) < $past(inputVoltageLimitMv, 2))
      else $error("vin status no drop");
   a_dis_rise_cause: assert property ($rose(statusEvents[3]) |->
      $past(dischargeCurrentMa, 2) != 16'h0000)
      else $error("dis status no current");
   a_bus_dis_mode: assert property (busDischargeTrigger |->
      $past(voltageAssistMode)) else $error("bus dis outside mode");
   a_unmapped_zero: assert property (
      (regAddr < 8'h36 || regAddr > 8'h39) |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
endmodule : hot_alert_chk

`default_nettype wire

/* File: host_port_model.sv */
// Purpose: host side of the decoded register port
// Assumes: one byte per transfer at the falling edge
// Notes: released write data shows the inverted byte
`default_nettype none

module host_port_model
(
   input  wire logic       mclk,
   input  wire logic [7:0] regRdData,
   output logic      [7:0] regAddr,
   output logic            regWrite,
   output logic      [7:0] regWrData
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
      {regAddr, regWrite, regWrData} = 17'h00000;

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      regAddr = a;
      regWrite = 1'b1;
      regWrData = d;
      @(negedge mclk);
      regWrite = 1'b0;
      regWrData = ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      regAddr = a;
      @(negedge mclk);
      d = regRdData;
   endtask : rd
endmodule : host_port_model

`default_nettype wire

/* File: test_hot_alert_profile_config.sv */
// Purpose: self-checking bench for the alert block
// Assumes: short deglitch counts, 1000 mA and 10000 mV limits
// Notes: host model drives registers
`default_nettype none

module test_hot_alert_profile_config;
   import hot_alert_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int CRIT_N [0:3] = '{4, 8, 12, 16};
   localparam int NOM_N [0:1]  = '{6, 10};
   localparam int DIS_N [0:3]  = '{5, 7, 9, 11};

   logic        mclk, rst_n, ce, regWrite, comparatorEvent, singleCell;
   logic        lowPowerMode, lowPowerAlertEnable, voltageAssistMode;
   logic        alertFunctionEnabled, busDischargeTrigger;
   logic        alertPinOut, alertPinOe;
   logic [1:0]  extraProfileBits;
   logic [7:0]  regAddr, regWrData, regRdData, statusEvents, rdv;
   logic [15:0] inputCurrentMa, inputCurrentLimitMa, inputVoltageMv;
   logic [15:0] inputVoltageLimitMv, systemVoltageMv, dischargeCurrentMa;
   int          error_cnt, n_compared, seed, code, lvl, n;
   int          regModel [4];

   hot_alert_profile_config #(
      .CRIT0_CYCLES(CRIT_N[0]), .CRIT1_CYCLES(CRIT_N[1]),
      .CRIT2_CYCLES(CRIT_N[2]), .CRIT3_CYCLES(CRIT_N[3]),
      .NOM0_CYCLES(NOM_N[0]), .NOM1_CYCLES(NOM_N[1]),
      .DIS0_CYCLES(DIS_N[0]), .DIS1_CYCLES(DIS_N[1]),
      .DIS2_CYCLES(DIS_N[2]), .DIS3_CYCLES(DIS_N[3]))
   uut (.mclk, .rst_n, .ce, .regAddr, .regWrite, .regWrData, .regRdData,
      .inputCurrentMa, .inputCurrentLimitMa, .inputVoltageMv,
      .inputVoltageLimitMv, .systemVoltageMv, .dischargeCurrentMa,
      .comparatorEvent, .singleCell, .lowPowerMode, .lowPowerAlertEnable,
      .voltageAssistMode, .extraProfileBits, .statusEvents,
      .alertFunctionEnabled, .busDischargeTrigger, .alertPinOut, .alertPinOe);

   host_port_model host (.mclk, .regRdData, .regAddr, .regWrite, .regWrData);

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   task automatic put(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d);
      if (a >= 8'h36 && a <= 8'h39)
         regModel[a - 8'h36] = d;
   endtask : put

   task automatic get(input logic [7:0] a);
      host.rd(a, rdv);
      check(rdv, (a >= 8'h36 && a <= 8'h39) ? regModel[a - 8'h36] : 0);
   endtask : get

   task automatic skip(input int k);
      repeat (k) @(negedge mclk);
   endtask : skip

   task automatic edgesTo(input int b);
      n = 0;
      do
      begin
         @(posedge mclk);
         #1;
         n++;
      end while (statusEvents[b] !== 1'b1 && n < 400);
      if (n >= 400)
      begin
         error_cnt++;
         complete_run();
      end
   endtask : edgesTo

   function automatic int pctOf(input int c);
      return (c <= 25) ? 105 + 5 * c : 250 + 50 * (c - 26);
   endfunction : pctOf

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      seed = 23533;
      {rst_n, comparatorEvent, singleCell, lowPowerMode} = 4'h0;
      {lowPowerAlertEnable, voltageAssistMode, extraProfileBits} = 4'h0;
      ce = 1'b1;
      inputCurrentMa = 16'h0000;
      inputCurrentLimitMa = 16'd1000;
      inputVoltageMv = 16'd20000;
      inputVoltageLimitMv = 16'd10000;
      systemVoltageMv = 16'd9000;
      dischargeCurrentMa = 16'h0000;
      regModel = '{8'h81, 8'h4A, 8'hA0, 8'h41};
      skip(20);
      rst_n = 1'b1;
      skip(2);
      for (int a = 8'h36; a <= 8'h3A; a++)
         get(8'(a));
      put(8'h39, 8'($random(seed)));
      get(8'h39);
      put(8'h40, 8'h5A);
      get(8'h40);
      // critical
      for (int d = 0; d < 4; d++)
      begin
         code = 1 + (($random(seed) & 32'h7FFF) % 30);
         put(8'h37, {code[4:0], d[1:0], 1'b0});
         lvl = pctOf(code) * 11;
         @(negedge mclk) inputCurrentMa = 16'(lvl);
         skip(CRIT_N[d] + 3);
         check(statusEvents[5], 0);
         @(negedge mclk) inputCurrentMa = 16'(lvl + 1);
         skip(CRIT_N[d] - 2);
         @(negedge mclk) inputCurrentMa = 16'h0000;
         @(negedge mclk) inputCurrentMa = 16'(lvl + 1);
         edgesTo(5);
         check(n, CRIT_N[d] + 1);
         check({alertPinOe, statusEvents[4]}, 2'b10);
         @(negedge mclk) inputCurrentMa = 16'h0000;
      end
      put(8'h37, 8'hFA);
      @(negedge mclk) inputCurrentMa = 16'hFFFF;
      skip(CRIT_N[1] + 4);
      check(statusEvents[5], 0);
      // nominal
      put(8'h38, 8'hB0);
      for (int d = 0; d < 2; d++)
      begin
         put(8'h36, 8'h81 | 8'(d << 1));
         @(negedge mclk) inputCurrentMa = 16'd1100;
         skip(NOM_N[d] + 3);
         check(statusEvents[4], 0);
         @(negedge mclk) inputCurrentMa = 16'd1101;
         edgesTo(4);
         check(n, NOM_N[d] + 1);
         @(negedge mclk) inputCurrentMa = 16'h0000;
      end
      // input voltage
      for (int k = 0; k < 3; k++)
      begin
         put(8'h36, (k == 2) ? 8'h80 : 8'h81);
         put(8'h37, 8'hFA | 8'(k == 1));
         lvl = (k == 0) ? 8300 : (k == 1) ? 9100 : 10000;
         @(negedge mclk) inputVoltageMv = 16'(lvl);
         skip(4);
         check(statusEvents[7], 0);
         @(negedge mclk) inputVoltageMv = 16'(lvl - 1);
         edgesTo(7);
         check(n, 2);
         @(negedge mclk) inputVoltageMv = 16'd20000;
      end
      // comparator
      @(negedge mclk) comparatorEvent = 1'b1;
      skip(3);
      check(statusEvents[6], 0);
      put(8'h38, 8'h40);
      skip(2);
      check({statusEvents[6], alertPinOe}, 2'b11);
      @(negedge mclk) lowPowerMode = 1'b1;
      skip(2);
      check(statusEvents[6], 0);
      @(negedge mclk) lowPowerAlertEnable = 1'b1;
      skip(2);
      check(statusEvents[6], 1);
      @(negedge mclk) {comparatorEvent, lowPowerMode} = 2'b00;
      put(8'h38, 8'h00);
      skip(3);
      check(alertFunctionEnabled, 0);
      @(negedge mclk) extraProfileBits = 2'(1 + (($random(seed) & 255) % 3));
      skip(3);
      check(alertFunctionEnabled, 1);
      // discharge
      put(8'h38, 8'h08);
      code = 1 + (($random(seed) & 32'h7FFF) % 62);
      for (int d = 0; d < 4; d++)
      begin
         put(8'h39, {code[5:0], d[1:0]});
         @(negedge mclk) dischargeCurrentMa = 16'(code * 1024);
         skip(DIS_N[d] + 3);
         check(statusEvents[3], 0);
         @(negedge mclk) dischargeCurrentMa = 16'(code * 1024 + 1);
         edgesTo(3);
         check(n, DIS_N[d] + 1);
         @(negedge mclk) dischargeCurrentMa = 16'h0000;
      end
      // system threshold
      @(negedge mclk) {voltageAssistMode, systemVoltageMv} = {1'b1, 16'd6399};
      skip(249);
      check(busDischargeTrigger, 0);
      skip(3);
      check(busDischargeTrigger, 1);
      @(negedge mclk) {singleCell, systemVoltageMv} = {1'b1, 16'd3200};
      skip(3);
      check(busDischargeTrigger, 0);
      // second reset
      rst_n = 1'b0;
      skip(3);
      rst_n = 1'b1;
      regModel = '{8'h09, 8'h4A, 8'hA0, 8'h41};
      get(8'h36);
      get(8'h38);
      complete_run();
   end
endmodule : test_hot_alert_profile_config

bind hot_alert_profile_config hot_alert_chk chk (.mclk, .rst_n, .regAddr,
   .regRdData, .inputCurrentMa, .inputCurrentLimitMa, .inputVoltageMv,
   .inputVoltageLimitMv, .dischargeCurrentMa, .comparatorEvent,
   .voltageAssistMode, .statusEvents, .busDischargeTrigger, .alertPinOut,
   .alertPinOe);

`default_nettype wire
